// ---- dev_ctrl_status_pkg.sv ----
/*
  Constants and the state type for the per-port device control and status register.
  Assumes a single 125 MHz core clock and a register port with byte addresses.
*/
package dev_ctrl_status_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] DEV_CTRL_STAT_OFF = 8'hC8;

  // error classes, shared by enables, detected flags and event inputs
  localparam int unsigned ERR_CORR = 0;
  localparam int unsigned ERR_NONFATAL = 1;
  localparam int unsigned ERR_FATAL = 2;
  localparam int unsigned ERR_UNSUP = 3;
  localparam int unsigned ERR_CLASSES = 4;

  // control half
  localparam int unsigned REPORT_EN_LSB = 0;
  localparam int unsigned RELAXED_ORD_BIT = 4;
  localparam int unsigned MAX_PAYLOAD_LSB = 5;
  localparam int unsigned MAX_PAYLOAD_MSB = 7;
  localparam int unsigned EXT_TAG_BIT = 8;
  localparam int unsigned PHANTOM_BIT = 9;
  localparam int unsigned AUX_PM_EN_BIT = 10;
  localparam int unsigned NO_SNOOP_BIT = 11;
  localparam int unsigned MAX_RD_REQ_LSB = 12;
  localparam int unsigned MAX_RD_REQ_MSB = 14;
  localparam int unsigned CTRL_RSVD_BIT = 15;

  // status half
  localparam int unsigned ERR_DET_LSB = 16;
  localparam int unsigned ERR_DET_MSB = 19;
  localparam int unsigned AUX_DET_BIT = 20;
  localparam int unsigned TRANS_PEND_BIT = 21;
  localparam int unsigned STAT_RSVD_LSB = 22;

  // reset and hardwired values
  localparam logic [3:0] REPORT_EN_RST = 4'h0;
  localparam logic [2:0] MAX_PAYLOAD_RST = 3'h0;
  localparam logic AUX_PM_EN_RST = 1'b0;
  localparam logic [3:0] ERR_DET_RST = 4'h0;
  localparam logic AUX_DET_RST = 1'b1;
  localparam logic [2:0] MAX_RD_REQ_VAL = 3'h0;
  localparam logic TRANS_PEND_VAL = 1'b0;

  // supported payload size codes
  localparam logic [2:0] MPS_SUP_SMALL = 3'h1;
  localparam logic [2:0] MPS_SUP_LARGE = 3'h2;

  typedef struct packed {
    logic [3:0] report_en;
    logic [2:0] max_payload;
    logic aux_pm_en;
    logic [3:0] err_detected;
    logic [1:0] strap_sync;
    logic [1:0] aux_sync;
    logic [3:0] report_pulse;
    logic [31:0] rdata;
  } ctrl_state_s;

  localparam ctrl_state_s STATE_RST = '{
    report_en: REPORT_EN_RST,
    max_payload: MAX_PAYLOAD_RST,
    aux_pm_en: AUX_PM_EN_RST,
    err_detected: ERR_DET_RST,
    strap_sync: 2'h0,
    aux_sync: {AUX_DET_RST, AUX_DET_RST},
    report_pulse: 4'h0,
    rdata: 32'h0
  };

endpackage

// ---- dev_ctrl_status.sv ----
/*
  Device control and status register of one switch port: reporting enables,
  clamped payload size, sticky aux power enable, write-one-to-clear error flags.
  Assumes error events are one-cycle pulses from logic on clk_i; the strap and
  aux power sense arrive from pins and are synchronised here.
*/
`timescale 1ns/100ps
`default_nettype none

module dev_ctrl_status (
  input wire logic clk_i, // core clock, 125 MHz
  input wire logic sys_rst_i, // async fundamental reset, active high
  input wire logic hot_rst_i, // sync hot reset, keeps sticky bits
  input wire logic [dev_ctrl_status_pkg::ADDR_W-1:0] addr_i, // register byte address
  input wire logic [31:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [31:0] rdata_o, // read data, cycle after rd_i
  input wire logic [3:0] err_event_i, // one-cycle error detections
  input wire logic large_payload_strap_i, // strap pin, async
  input wire logic mps_override_en_i, // sideband/eeprom override valid
  input wire logic [2:0] mps_override_code_i, // override supported code
  input wire logic aux_power_sense_i, // aux power detect pin, async
  output logic [3:0] report_o, // one-cycle error reports upstream
  output logic [3:0] report_en_o, // current reporting enables
  output logic [2:0] max_payload_o, // programmed payload size code
  output logic [2:0] max_payload_sup_o, // supported payload size code
  output logic aux_pm_en_o // aux power draw enable
);

  dev_ctrl_status_pkg::ctrl_state_s st_q;
  dev_ctrl_status_pkg::ctrl_state_s st_d;
  logic hit;
  logic wr_hit;
  logic rd_hit;
  logic [2:0] sup_code;
  logic [2:0] wr_mps;
  logic [3:0] w1c;
  logic [31:0] read_word;

  assign hit = (addr_i == dev_ctrl_status_pkg::DEV_CTRL_STAT_OFF);
  assign wr_hit = wr_i & hit;
  assign rd_hit = rd_i & hit;

  // strap may be superseded by sideband or eeprom load
  assign sup_code = mps_override_en_i ? mps_override_code_i :
                    (st_q.strap_sync[1] ? dev_ctrl_status_pkg::MPS_SUP_LARGE :
                     dev_ctrl_status_pkg::MPS_SUP_SMALL);

  assign wr_mps = wdata_i[dev_ctrl_status_pkg::MAX_PAYLOAD_MSB:
                          dev_ctrl_status_pkg::MAX_PAYLOAD_LSB];
  assign w1c = wr_hit ? wdata_i[dev_ctrl_status_pkg::ERR_DET_MSB:
                                dev_ctrl_status_pkg::ERR_DET_LSB] : 4'h0;

  // unlisted bits stay zero: hardwired and reserved fields
  always_comb begin
    read_word = 32'h0;
    read_word[dev_ctrl_status_pkg::REPORT_EN_LSB +: 4] = st_q.report_en;
    read_word[dev_ctrl_status_pkg::MAX_PAYLOAD_LSB +: 3] = st_q.max_payload;
    read_word[dev_ctrl_status_pkg::AUX_PM_EN_BIT] = st_q.aux_pm_en;
    read_word[dev_ctrl_status_pkg::MAX_RD_REQ_LSB +: 3] = dev_ctrl_status_pkg::MAX_RD_REQ_VAL;
    read_word[dev_ctrl_status_pkg::ERR_DET_LSB +: 4] = st_q.err_detected;
    read_word[dev_ctrl_status_pkg::AUX_DET_BIT] = st_q.aux_sync[1];
    read_word[dev_ctrl_status_pkg::TRANS_PEND_BIT] = dev_ctrl_status_pkg::TRANS_PEND_VAL;
  end

  always_comb begin
    st_d = st_q;
    st_d.strap_sync = {st_q.strap_sync[0], large_payload_strap_i};
    st_d.aux_sync = {st_q.aux_sync[0], aux_power_sense_i};
    // unmapped reads and idle cycles return zero
    st_d.rdata = rd_hit ? read_word : 32'h0;
    // reports follow enables; detection below ignores them
    st_d.report_pulse = err_event_i & st_q.report_en;
    if (wr_hit) begin
      st_d.report_en = wdata_i[dev_ctrl_status_pkg::REPORT_EN_LSB +: 4];
      st_d.max_payload = (wr_mps > sup_code) ? sup_code : wr_mps;
      st_d.aux_pm_en = wdata_i[dev_ctrl_status_pkg::AUX_PM_EN_BIT];
    end
    // set wins over a same-cycle clear so no event is lost
    st_d.err_detected = (st_q.err_detected & ~w1c) | err_event_i;
    if (hot_rst_i) begin
      // sticky aux enable, synchronisers and read data survive; enables, payload size, flags and reports return to reset
      st_d.report_en = dev_ctrl_status_pkg::REPORT_EN_RST;
      st_d.max_payload = dev_ctrl_status_pkg::MAX_PAYLOAD_RST;
      st_d.err_detected = dev_ctrl_status_pkg::ERR_DET_RST;
      st_d.report_pulse = 4'h0;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= dev_ctrl_status_pkg::STATE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_o = st_q.rdata;
  assign report_o = st_q.report_pulse;
  assign report_en_o = st_q.report_en;
  assign max_payload_o = st_q.max_payload;
  assign max_payload_sup_o = sup_code;
  assign aux_pm_en_o = st_q.aux_pm_en;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  en_write_a: assert property (
    (wr_hit && !hot_rst_i) |=> (report_en_o == $past(wdata_i[3:0])))
    else $error("reporting enables did not take written value");

  report_gate_a: assert property (
    (err_event_i[1] && !report_en_o[1] && !hot_rst_i) |=> !report_o[1])
    else $error("non-fatal report escaped a cleared enable");

  report_pass_a: assert property (
    (err_event_i[2] && report_en_o[2] && !hot_rst_i && !wr_hit)
    |=> report_o[2] ##1 (!report_o[2] || err_event_i[2] || $past(err_event_i[2])))
    else $error("fatal report not issued for one cycle");

  mps_clamp_a: assert property (
    (wr_hit && !hot_rst_i) |=> (max_payload_o == (($past(wr_mps) > $past(sup_code)) ?
                                $past(sup_code) : $past(wr_mps))))
    else $error("payload size not clamped to supported code");

  sup_code_a: assert property (
    !mps_override_en_i |-> (max_payload_sup_o == (st_q.strap_sync[1] ? 3'h2 : 3'h1)))
    else $error("supported payload code does not follow strap");

  sticky_aux_a: assert property (
    (hot_rst_i && !wr_hit) |=> $stable(aux_pm_en_o))
    else $error("sticky aux enable lost on hot reset");

  err_set_a: assert property (
    (err_event_i[0] && !hot_rst_i) |=> st_q.err_detected[0])
    else $error("correctable flag not set on detection");

  err_hold_a: assert property (
    (st_q.err_detected[3] && !w1c[3] && !hot_rst_i) |=> st_q.err_detected[3])
    else $error("unsupported request flag dropped without clear");

  err_clear_a: assert property (
    (w1c[1] && !err_event_i[1]) |=> !st_q.err_detected[1])
    else $error("non-fatal flag not cleared by write one");

  ro_zero_a: assert property (
    rd_i |=> (rdata_o[31:21] == 11'h0) && (rdata_o[15:11] == 5'h0) &&
             (rdata_o[9:8] == 2'h0) && !rdata_o[4])
    else $error("hardwired or reserved bits read nonzero");

  read_back_a: assert property (
    rd_hit |=> (rdata_o[20] == $past(st_q.aux_sync[1])) &&
               (rdata_o[19:16] == $past(st_q.err_detected)))
    else $error("status half does not reflect state");

  idle_zero_a: assert property (
    !rd_hit |=> (rdata_o == 32'h0))
    else $error("read data not zero outside a read");

  // first edge after fundamental reset still shows the reset image
  rst_ctrl_a: assert property (
    $fell(sys_rst_i)
    |-> (report_en_o == dev_ctrl_status_pkg::REPORT_EN_RST) &&
        (max_payload_o == dev_ctrl_status_pkg::MAX_PAYLOAD_RST))
    else $error("control fields not at reset value");

  rst_flags_a: assert property (
    $fell(sys_rst_i)
    |-> (st_q.err_detected == dev_ctrl_status_pkg::ERR_DET_RST))
    else $error("detected flags not at reset value");

  rst_sticky_a: assert property (
    $fell(sys_rst_i)
    |-> (aux_pm_en_o == dev_ctrl_status_pkg::AUX_PM_EN_RST))
    else $error("aux enable not at reset value");

  rst_aux_a: assert property (
    $fell(sys_rst_i)
    |-> (st_q.aux_sync[1] == dev_ctrl_status_pkg::AUX_DET_RST))
    else $error("aux detected not at reset value");

  rst_rdata_a: assert property (
    $fell(sys_rst_i)
    |-> (rdata_o == 32'h0) && (report_o == 4'h0))
    else $error("read data or reports not idle after reset");

  // sticky enable: only a mapped write may move it, hot reset never
  aux_write_a: assert property (
    wr_hit
    |=> (aux_pm_en_o == $past(wdata_i[dev_ctrl_status_pkg::AUX_PM_EN_BIT])))
    else $error("aux enable did not take written value");

  aux_hold_a: assert property (
    !wr_hit
    |=> $stable(aux_pm_en_o))
    else $error("aux enable moved without a write");

  en_hold_a: assert property (
    (!wr_hit && !hot_rst_i)
    |=> $stable(report_en_o))
    else $error("reporting enables moved without a write");

  en_hotrst_a: assert property (
    hot_rst_i
    |=> (report_en_o == dev_ctrl_status_pkg::REPORT_EN_RST))
    else $error("reporting enables survived hot reset");

  mps_hold_a: assert property (
    (!wr_hit && !hot_rst_i)
    |=> $stable(max_payload_o))
    else $error("payload size moved without a write");

  mps_hotrst_a: assert property (
    hot_rst_i
    |=> (max_payload_o == dev_ctrl_status_pkg::MAX_PAYLOAD_RST))
    else $error("payload size survived hot reset");

  // clamp is judged against the supported code seen at write time
  mps_bound_a: assert property (
    (wr_hit && !hot_rst_i)
    |=> (max_payload_o <= $past(sup_code)))
    else $error("stored payload size above supported code");

  mps_keep_a: assert property (
    (wr_hit && !hot_rst_i && (wr_mps <= sup_code))
    |=> (max_payload_o == $past(wr_mps)))
    else $error("legal payload size not stored as written");

  sup_override_a: assert property (
    mps_override_en_i
    |-> (max_payload_sup_o == mps_override_code_i))
    else $error("override code not used as supported code");

  sup_large_a: assert property (
    (!mps_override_en_i && st_q.strap_sync[1])
    |-> (max_payload_sup_o == dev_ctrl_status_pkg::MPS_SUP_LARGE))
    else $error("large strap does not give large code");

  sup_small_a: assert property (
    (!mps_override_en_i && !st_q.strap_sync[1])
    |-> (max_payload_sup_o == dev_ctrl_status_pkg::MPS_SUP_SMALL))
    else $error("small strap does not give small code");

  // pins pass two flops; a shortcut here would invite metastability
  strap_path_a: assert property (
    1'b1
    |=> (st_q.strap_sync[1] == $past(st_q.strap_sync[0])))
    else $error("strap synchroniser skipped a stage");

  aux_path_a: assert property (
    1'b1
    |=> (st_q.aux_sync[1] == $past(st_q.aux_sync[0])))
    else $error("aux sense synchroniser skipped a stage");

  ctrl_read_a: assert property (
    rd_hit
    |=> (rdata_o[7:5] == $past(max_payload_o)) && (rdata_o[3:0] == $past(report_en_o)) &&
        (rdata_o[10] == $past(aux_pm_en_o)))
    else $error("control half does not reflect state");

  relaxed_zero_a: assert property (
    rd_i
    |=> !rdata_o[dev_ctrl_status_pkg::RELAXED_ORD_BIT])
    else $error("relaxed ordering bit read nonzero");

  ext_tag_zero_a: assert property (
    rd_i
    |=> !rdata_o[dev_ctrl_status_pkg::EXT_TAG_BIT] && !rdata_o[dev_ctrl_status_pkg::PHANTOM_BIT])
    else $error("extended tag or phantom bit read nonzero");

  no_snoop_zero_a: assert property (
    rd_i
    |=> !rdata_o[dev_ctrl_status_pkg::NO_SNOOP_BIT])
    else $error("no snoop bit read nonzero");

  rd_req_zero_a: assert property (
    rd_i
    |=> (rdata_o[14:12] == dev_ctrl_status_pkg::MAX_RD_REQ_VAL))
    else $error("read request size not hardwired");

  pend_zero_a: assert property (
    rd_i
    |=> (rdata_o[dev_ctrl_status_pkg::TRANS_PEND_BIT] == dev_ctrl_status_pkg::TRANS_PEND_VAL))
    else $error("transactions pending read nonzero");

  ctrl_rsvd_a: assert property (
    rd_i
    |=> !rdata_o[dev_ctrl_status_pkg::CTRL_RSVD_BIT])
    else $error("reserved control bit read nonzero");

  stat_rsvd_a: assert property (
    rd_i
    |=> (rdata_o[31:dev_ctrl_status_pkg::STAT_RSVD_LSB] == 10'h0))
    else $error("reserved status bits read nonzero");

  unmapped_rd_a: assert property (
    (rd_i && !hit)
    |=> (rdata_o == 32'h0))
    else $error("unmapped read returned data");

  // writes elsewhere must not leak into this register
  unmapped_wr_a: assert property (
    (wr_i && !hit && !hot_rst_i)
    |=> $stable(report_en_o) && $stable(max_payload_o) && $stable(aux_pm_en_o))
    else $error("unmapped write changed control fields");

  // every error class behaves alike, so one loop checks all four
  for (genvar k = 0; k < dev_ctrl_status_pkg::ERR_CLASSES; k++) begin : g_class
    flag_set_a: assert property (
      (err_event_i[k] && !hot_rst_i)
      |=> st_q.err_detected[k])
      else $error("detected flag not set by its event");

    flag_hold_a: assert property (
      (st_q.err_detected[k] && !w1c[k] && !hot_rst_i)
      |=> st_q.err_detected[k])
      else $error("detected flag dropped without clear");

    flag_clear_a: assert property (
      (w1c[k] && !err_event_i[k])
      |=> !st_q.err_detected[k])
      else $error("detected flag not cleared by write one");

    flag_zero_keep_a: assert property (
      (st_q.err_detected[k] && wr_hit && !wdata_i[dev_ctrl_status_pkg::ERR_DET_LSB + k] &&
       !hot_rst_i)
      |=> st_q.err_detected[k])
      else $error("writing zero cleared a detected flag");

    flag_quiet_a: assert property (
      (!st_q.err_detected[k] && !err_event_i[k])
      |=> !st_q.err_detected[k])
      else $error("detected flag set without an event");

    flag_hotrst_a: assert property (
      hot_rst_i
      |=> !st_q.err_detected[k])
      else $error("detected flag survived hot reset");

    report_on_a: assert property (
      (err_event_i[k] && report_en_o[k] && !hot_rst_i)
      |=> report_o[k])
      else $error("enabled error not reported");

    report_off_a: assert property (
      (!err_event_i[k] || !report_en_o[k] || hot_rst_i)
      |=> !report_o[k])
      else $error("report issued without enabled event");

    report_indep_a: assert property (
      (err_event_i[k] && !report_en_o[k] && !hot_rst_i)
      |=> st_q.err_detected[k] && !report_o[k])
      else $error("logging depends on reporting enable");
  end

endmodule
`default_nettype wire

// ---- err_source.sv ----
/*
  Error source model standing in for the port's link and transaction logic.
  Assumes the bench asks for events one cycle ahead, on clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module err_source (
  input wire logic clk_i, // core clock
  input wire logic sys_rst_i, // async reset
  input wire logic [3:0] fire_i, // classes to raise
  output logic [3:0] err_event_o // one-cycle detections
);
  // registered, so each pulse repeats fire_i one cycle later and lasts as long as fire_i is held
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      err_event_o <= 4'h0;
    end else begin
      err_event_o <= fire_i;
    end
  end
endmodule
`default_nettype wire

// ---- pcie_switch_device_ctrl_status_test.sv ----
/*
  Self-checking bench for the device control and status register.
  Assumes the design package and the error source model compile first.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module pcie_switch_device_ctrl_status_test;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, hot_rst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o, seed = 32'h17, rd_v, w;
  logic [3:0] fire = 4'h0, err_event_i, report_o, report_en_o, flags = 4'h0;
  logic strap = 1'b0, ovr_en = 1'b0, aux_sense = 1'b1, aux_pm_en_o;
  logic [2:0] ovr_code = 3'h0, max_payload_o, max_payload_sup_o;
  logic [15:0] ctrl = 16'h0;
  int n_fail = 0, n_compared = 0, cyc = 0;
  err_source u_src (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .fire_i(fire),
    .err_event_o(err_event_i));
  dev_ctrl_status u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hot_rst_i(hot_rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .err_event_i(err_event_i), .large_payload_strap_i(strap), .mps_override_en_i(ovr_en),
    .mps_override_code_i(ovr_code), .aux_power_sense_i(aux_sense), .report_o(report_o),
    .report_en_o(report_en_o), .max_payload_o(max_payload_o),
    .max_payload_sup_o(max_payload_sup_o), .aux_pm_en_o(aux_pm_en_o));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // oversize payload codes clamp to the supported code at write time
  function automatic logic [15:0] exp_ctrl(input logic [15:0] d, input logic [2:0] sup);
    exp_ctrl = {5'h00, d[10], 2'h0, (d[7:5] > sup) ? sup : d[7:5], 1'b0, d[3:0]};
  endfunction
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 rd_v = rdata_o;
  endtask
  task automatic chk_reg();
    rd(8'hC8);
    `CHK(rd_v, {10'h000, 1'b0, aux_sense, flags, ctrl})
    `CHK({aux_pm_en_o, max_payload_o, report_en_o}, {ctrl[10], ctrl[7:5], ctrl[3:0]})
  endtask
  task automatic ev(input logic [3:0] m);
    @(posedge clk_i);
    fire <= m;
    @(posedge clk_i);
    fire <= 4'h0;
    @(posedge clk_i);
    #1 `CHK(report_o, m & ctrl[3:0])
    flags = flags | m;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(8'hC8);
    `CHK(rd_v, 32'h0010_0000)
    wr(8'hC8, 32'hFFFF_FFFF);
    ctrl = exp_ctrl(16'hFFFF, 3'h1);
    chk_reg();
    `CHK(rd_v[15:0], 16'h042F)
    wr(8'hC4, 32'h0000_0000);
    rd(8'hC4);
    `CHK(rd_v, 32'h0)
    chk_reg();
    $display("test fixed values done");
    for (int i = 0; i < 40; i++) begin
      w = xs();
      @(posedge clk_i);
      strap <= w[31];
      repeat (3) @(posedge clk_i);
      `CHK(max_payload_sup_o, w[31] ? 3'h2 : 3'h1)
      wr(8'hC8, w);
      ctrl = exp_ctrl(w[15:0], w[31] ? 3'h2 : 3'h1);
      flags = flags & ~w[19:16];
      chk_reg();
      ev(w[23:20]);
      chk_reg();
    end
    $display("test random traffic done");
    @(posedge clk_i);
    ovr_en <= 1'b1;
    ovr_code <= 3'h3;
    wr(8'hC8, 32'h0000_00E0);
    ctrl = exp_ctrl(16'h00E0, 3'h3);
    chk_reg();
    wr(8'hC8, 32'h000F_040F);
    ctrl = 16'h040F;
    flags = 4'h0;
    ev(4'hF);
    @(posedge clk_i);
    hot_rst_i <= 1'b1;
    @(posedge clk_i);
    hot_rst_i <= 1'b0;
    ctrl = 16'h0400;
    flags = 4'h0;
    chk_reg();
    @(posedge clk_i);
    aux_sense <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk_reg();
    $display("test override and hot reset done");
    conclude();
  end
endmodule
`default_nettype wire
